// ==== can_error_detect_confine.sv ====
// can error detection, error frame signalling and fault confinement with apb registers
`timescale 1ns/1ps

module can_error_detect_confine
   import can_edc_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              ce,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire frame_ctx_t        ctx,
   input  wire logic              can_rx,
   output logic                   can_tx,
   output logic                   can_tx_oe,
   output logic                   rx_enable,
   output logic                   tx_allowed,
   output logic                   arb_lost,
   output err_evt_t               err_evt,
   output fault_t                 fault_state
);

   // a sized literal cannot be part-selected, so the polynomial gets a name first
   localparam logic [15:0] CRC_POLY_P = `CRC_POLY;

   st_t s_q;
   st_t s_d;

   function automatic logic is_stuffed(input field_t f);
      case (f)
         F_SOF, F_ARB, F_CTRL, F_DATA, F_CRC: is_stuffed = 1'b1;
         default:                             is_stuffed = 1'b0;
      endcase
   endfunction : is_stuffed

   function automatic logic is_crc_covered(input field_t f);
      case (f)
         F_SOF, F_ARB, F_CTRL, F_DATA: is_crc_covered = 1'b1;
         default:                      is_crc_covered = 1'b0;
      endcase
   endfunction : is_crc_covered

   function automatic logic is_fixed_form(input field_t f);
      case (f)
         F_CRC_DELIM, F_ACK_DELIM, F_EOF, F_IFS: is_fixed_form = 1'b1;
         default:                                is_fixed_form = 1'b0;
      endcase
   endfunction : is_fixed_form

   function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
      reg_hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
   endfunction : reg_hit

   always_comb begin
      logic     rx;
      logic     in_frame;
      logic     stuff_bit;
      logic     fb;
      logic     err_any;
      logic     err_tx;
      err_evt_t e;
      logic     access;
      rx        = s_q.rx_s2;
      in_frame  = 1'b0;
      stuff_bit = 1'b0;
      fb        = 1'b0;
      err_any   = 1'b0;
      err_tx    = 1'b0;
      e         = '0;
      access    = 1'b0;

      s_d          = s_q;
      s_d.evt      = '0;
      s_d.arb_lost = 1'b0;
      s_d.rx_s1    = can_rx;
      s_d.rx_s2    = s_q.rx_s1;

      in_frame = (s_q.fault != FS_BUS_OFF) && !s_q.init && (s_q.ef == EF_NONE);

      if (ctx.tick && in_frame) begin
         // destuffing check; stuff bits are neither data nor crc input
         if (is_stuffed(ctx.field)) begin
            if (s_q.same_cnt == `STUFF_LIMIT) begin
               stuff_bit = 1'b1;
               if (rx == s_q.last_bit)
                  e.stuff_err = 1'b1;
               s_d.same_cnt = 3'h1;
            end else if (s_q.same_cnt != 3'h0 && rx == s_q.last_bit) begin
               s_d.same_cnt = s_q.same_cnt + 3'h1;
            end else begin
               s_d.same_cnt = 3'h1;
            end
            s_d.last_bit = rx;
         end else begin
            s_d.same_cnt = 3'h0;
         end

         // crc over sof..data, then compared bit by bit with the received sequence
         if (ctx.field == F_IDLE || ctx.field == F_IFS) begin
            s_d.crc     = '0;
            s_d.crc_bad = 1'b0;
         end else if (!stuff_bit && is_crc_covered(ctx.field)) begin
            fb      = rx ^ s_q.crc[`CRC_W-1];
            s_d.crc = {s_q.crc[`CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY_P[`CRC_W-1:0] : '0);
         end else if (!stuff_bit && ctx.field == F_CRC) begin
            if (rx != s_q.crc[`CRC_W-1])
               s_d.crc_bad = 1'b1;
            s_d.crc = {s_q.crc[`CRC_W-2:0], 1'b0};
         end

         // flagged after the ack delimiter so a good receiver still acknowledges
         if (ctx.field == F_ACK_DELIM && !ctx.transmitting && s_q.crc_bad)
            e.crc_err = 1'b1;

         if (is_fixed_form(ctx.field)) begin
            if (!rx)
               e.form_err = 1'b1;
         end else if (ctx.transmitting) begin
            if (ctx.field == F_ACK_SLOT) begin
               if (rx)
                  e.ack_err = 1'b1;
            end else if (ctx.field == F_ARB && ctx.tx_level && !rx) begin
               s_d.arb_lost = 1'b1;
            end else if (rx != ctx.tx_level) begin
               e.bit_err = 1'b1;
            end
         end

         err_any = |e;
         err_tx  = ctx.transmitting;
         s_d.evt = e;

         if (err_any) begin
            s_d.ef       = EF_FLAG;
            s_d.ef_cnt   = 4'h0;
            s_d.eq_cnt   = 3'h0;
            s_d.ef_tx    = err_tx;
            s_d.same_cnt = 3'h0;
            // passive transmitter that gets no ack gets no increment, so ack errors alone never bring it to bus-off
            if (err_tx) begin
               if (!(e.ack_err && s_q.fault == FS_PASSIVE))
                  s_d.tec = s_q.tec + `TEC_INC;
            end else if (s_q.rec < `REC_CAP) begin
               s_d.rec = s_q.rec + `REC_INC;
            end
         end
      end else if (ctx.tick && s_q.ef != EF_NONE) begin
         case (s_q.ef)
            EF_FLAG: begin
               s_d.ef_cnt  = s_q.ef_cnt + 4'h1;
               s_d.ef_last = rx;
               if (s_q.eq_cnt != 3'h0 && rx == s_q.ef_last) begin
                  if (s_q.eq_cnt != `PASSIVE_EQ_BITS)
                     s_d.eq_cnt = s_q.eq_cnt + 3'h1;
               end else begin
                  s_d.eq_cnt = 3'h1;
               end
               if (s_q.fault == FS_ACTIVE) begin
                  if (s_q.ef_cnt == `ERR_FLAG_BITS - 4'h1)
                     s_d.ef = EF_WAIT_REC;
               end else if (s_q.ef_cnt >= `ERR_FLAG_BITS - 4'h1 && s_d.eq_cnt == `PASSIVE_EQ_BITS) begin
                  s_d.ef = EF_WAIT_REC;
               end
            end
            EF_WAIT_REC: begin
               // other nodes may still hold their flags dominant
               if (rx) begin
                  s_d.ef     = EF_DELIM;
                  s_d.ef_cnt = 4'h1;
               end
            end
            EF_DELIM: begin
               if (s_q.ef_cnt == `ERR_DELIM_BITS - 4'h1) begin
                  s_d.ef = EF_NONE;
                  if (s_q.ef_tx && s_q.fault == FS_PASSIVE)
                     s_d.susp_cnt = `IFS_BITS + `SUSP_EXTRA_BITS;
               end else begin
                  s_d.ef_cnt = s_q.ef_cnt + 4'h1;
               end
            end
            default: s_d.ef = EF_NONE;
         endcase
      end

      // suspend transmission; a dominant bit means another node started, so we receive
      if (ctx.tick && s_q.susp_cnt != 4'h0)
         s_d.susp_cnt = rx ? s_q.susp_cnt - 4'h1 : 4'h0;

      if (ctx.frame_done && in_frame && s_d.ef == EF_NONE) begin
         if (ctx.transmitting) begin
            if (s_q.tec != 9'h000)
               s_d.tec = s_q.tec - `ERR_DEC;
            if (s_q.fault == FS_PASSIVE)
               s_d.susp_cnt = `IFS_BITS + `SUSP_EXTRA_BITS;
         end else if (s_q.rec != 9'h000) begin
            s_d.rec = s_q.rec - `ERR_DEC;
         end
      end

      // apb: answer one cycle after setup; write acts at the completing edge
      access      = psel && penable && s_q.pready;
      s_d.pready  = psel && !penable;
      s_d.pslverr = 1'b0;
      s_d.prdata  = '0;
      if (psel && !penable) begin
         if (reg_hit(paddr, `CTRL_IDX)) begin
            s_d.prdata[`CTRL_INIT_POS] = s_q.init;
         end else if (reg_hit(paddr, `STAT_IDX)) begin
            s_d.prdata[`STAT_BUS_OFF_FLAG_POS]                    = (s_q.fault == FS_BUS_OFF);
            s_d.prdata[`STAT_ERR_POS]                     = (s_q.fault != FS_ACTIVE);
            s_d.prdata[`STAT_FAULT_LSB+1:`STAT_FAULT_LSB] = s_q.fault;
         end else begin
            s_d.pslverr = 1'b1;
         end
      end
      if (access && pwrite && reg_hit(paddr, `CTRL_IDX)) begin
         s_d.init = pwdata[`CTRL_INIT_POS];
         s_d.rcv_grp  = 8'h00;
         s_d.rcv_bits = 4'h0;
      end

      // bus-off recovery counts groups of recessive bits once the hold is released
      if (s_q.fault == FS_BUS_OFF && !s_q.init && ctx.tick) begin
         if (!rx) begin
            s_d.rcv_bits = 4'h0;
         end else if (s_q.rcv_bits == `RECOV_GROUP_BITS - 4'h1) begin
            s_d.rcv_bits = 4'h0;
            if (s_q.rcv_grp == `RECOV_GROUPS - 8'h01) begin
               s_d.fault   = FS_ACTIVE;
               s_d.tec     = 9'h000;
               s_d.rec     = 9'h000;
               s_d.rcv_grp = 8'h00;
            end else begin
               s_d.rcv_grp = s_q.rcv_grp + 8'h01;
            end
         end else begin
            s_d.rcv_bits = s_q.rcv_bits + 4'h1;
         end
      end else if (s_q.fault != FS_BUS_OFF) begin
         // hardware set of the hold wins over a software clear in the same cycle
         if (s_d.tec > `BUS_OFF_FLAG_LIMIT) begin
            s_d.fault    = FS_BUS_OFF;
            s_d.init     = 1'b1;
            s_d.ef       = EF_NONE;
            s_d.susp_cnt = 4'h0;
            s_d.rcv_grp  = 8'h00;
            s_d.rcv_bits = 4'h0;
         end else if (s_d.tec > `PASSIVE_LIMIT || s_d.rec > `PASSIVE_LIMIT) begin
            s_d.fault = FS_PASSIVE;
         end else begin
            s_d.fault = FS_ACTIVE;
         end
      end

      // output pins, one cycle behind the engine's intended level
      s_d.can_tx_oe = (s_d.fault != FS_BUS_OFF);
      s_d.rx_en     = (s_d.fault != FS_BUS_OFF) && !s_d.init;
      s_d.tx_ok     = s_d.rx_en && s_d.ef == EF_NONE && s_d.susp_cnt == 4'h0;
      if (s_d.ef == EF_FLAG)
         s_d.can_tx = (s_d.fault == FS_PASSIVE);
      else if (s_d.tx_ok && ctx.transmitting)
         s_d.can_tx = ctx.tx_level;
      else
         s_d.can_tx = 1'b1;
   end

   // tallies live only in s_q and are never mapped onto the bus
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // synchronisers start recessive so no false dominant bit follows reset
         s_q.rx_s1     <= 1'b1;
         s_q.rx_s2     <= 1'b1;
         s_q.init      <= `CTRL_INIT_RST;
         s_q.fault     <= FS_ACTIVE;
         s_q.tec       <= 9'h000;
         s_q.rec       <= 9'h000;
         s_q.same_cnt  <= 3'h0;
         s_q.last_bit  <= 1'b0;
         s_q.crc       <= '0;
         s_q.crc_bad   <= 1'b0;
         s_q.ef        <= EF_NONE;
         s_q.ef_cnt    <= 4'h0;
         s_q.eq_cnt    <= 3'h0;
         s_q.ef_last   <= 1'b0;
         s_q.ef_tx     <= 1'b0;
         s_q.susp_cnt  <= 4'h0;
         s_q.rcv_grp   <= 8'h00;
         s_q.rcv_bits  <= 4'h0;
         // the line stays recessive and driven until software releases the hold
         s_q.can_tx    <= 1'b1;
         s_q.can_tx_oe <= 1'b1;
         s_q.rx_en     <= 1'b0;
         s_q.tx_ok     <= 1'b0;
         s_q.evt       <= '0;
         s_q.arb_lost  <= 1'b0;
         s_q.pready    <= 1'b0;
         s_q.prdata    <= 32'h0000_0000;
         s_q.pslverr   <= 1'b0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign prdata      = s_q.prdata;
   assign pready      = s_q.pready;
   assign pslverr     = s_q.pslverr;
   assign can_tx      = s_q.can_tx;
   assign can_tx_oe   = s_q.can_tx_oe;
   assign rx_enable   = s_q.rx_en;
   assign tx_allowed  = s_q.tx_ok;
   assign arb_lost    = s_q.arb_lost;
   assign err_evt     = s_q.evt;
   assign fault_state = s_q.fault;

endmodule : can_error_detect_confine

// ==== can_edc_cfg.svh ====
// constants of the can error detection and fault confinement block
`ifndef CAN_EDC_CFG_SVH
`define CAN_EDC_CFG_SVH

// register indices; byte address is four times the index
`define CTRL_IDX          8'h00
`define STAT_IDX          8'h01
`define CTRL_INIT_POS     0
`define STAT_BUS_OFF_FLAG_POS     7
`define STAT_ERR_POS      6
`define STAT_FAULT_LSB    0
`define CTRL_INIT_RST     1'b1

// crc
`define CRC_POLY          16'hc599
`define CRC_W             15
`define CRC_MAX_BITS      8'h7f

// bit counts
`define STUFF_LIMIT       3'h5
`define ERR_FLAG_BITS     4'h6
`define ERR_DELIM_BITS    4'h8
`define PASSIVE_EQ_BITS   3'h6
`define IFS_BITS          4'h3
`define SUSP_EXTRA_BITS   4'h7
`define RECOV_GROUP_BITS  4'hb
`define RECOV_GROUPS      8'h80

// error tallies
`define TEC_INC           9'h008
`define REC_INC           9'h001
`define ERR_DEC           9'h001
`define PASSIVE_LIMIT     9'h07f
`define BUS_OFF_FLAG_LIMIT        9'h0ff
`define REC_CAP           9'h0ff

`endif

// ==== can_edc_pkg.sv ====
// types of the can error detection and fault confinement block
`include "can_edc_cfg.svh"

package can_edc_pkg;

   typedef enum logic [3:0] {
      F_IDLE, F_SOF, F_ARB, F_CTRL, F_DATA, F_CRC,
      F_CRC_DELIM, F_ACK_SLOT, F_ACK_DELIM, F_EOF, F_IFS
   } field_t;

   typedef enum logic [1:0] {
      FS_ACTIVE, FS_PASSIVE, FS_BUS_OFF
   } fault_t;

   typedef enum logic [1:0] {
      EF_NONE, EF_FLAG, EF_WAIT_REC, EF_DELIM
   } ef_state_t;

   // per-bit context from the protocol engine, same clock
   typedef struct packed {
      logic   tick;
      logic   transmitting;
      logic   tx_level;
      field_t field;
      logic   frame_done;
   } frame_ctx_t;

   typedef struct packed {
      logic bit_err;
      logic stuff_err;
      logic crc_err;
      logic form_err;
      logic ack_err;
   } err_evt_t;

   typedef struct packed {
      logic                   rx_s1;
      logic                   rx_s2;
      logic                   init;
      fault_t                 fault;
      logic [8:0]             tec;
      logic [8:0]             rec;
      logic [2:0]             same_cnt;
      logic                   last_bit;
      logic [`CRC_W-1:0]      crc;
      logic                   crc_bad;
      ef_state_t              ef;
      logic [3:0]             ef_cnt;
      logic [2:0]             eq_cnt;
      logic                   ef_last;
      logic                   ef_tx;
      logic [3:0]             susp_cnt;
      logic [7:0]             rcv_grp;
      logic [3:0]             rcv_bits;
      logic                   can_tx;
      logic                   can_tx_oe;
      logic                   rx_en;
      logic                   tx_ok;
      err_evt_t               evt;
      logic                   arb_lost;
      logic                   pready;
      logic [31:0]            prdata;
      logic                   pslverr;
   } st_t;

endpackage : can_edc_pkg

// ==== can_edc_asserts.sv ====
// port-level assertions for the can error detection and confinement block
`timescale 1ns/1ps
module can_edc_asserts
   import can_edc_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              ce,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire frame_ctx_t        ctx,
   input wire logic              can_rx,
   input wire logic              can_tx,
   input wire logic              can_tx_oe,
   input wire logic              rx_enable,
   input wire logic              tx_allowed,
   input wire logic              arb_lost,
   input wire err_evt_t          err_evt,
   input wire fault_t            fault_state
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // a transmit check only counts when detection is not refused
   wire tx_chk = ce && ctx.tick && rx_enable && tx_allowed && ctx.transmitting;

   AST_APB_ANSWER: assert property (psel && !penable && ce |=> pready)
      else $error("no answer one cycle after setup");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("pready stood longer than one cycle");
   AST_ALIGN_ERR: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr && prdata == 32'h0)
      else $error("unaligned access not refused");
   AST_FAULT_ONE: assert property (fault_state inside {FS_ACTIVE, FS_PASSIVE, FS_BUS_OFF})
      else $error("fault state outside the three states");
   AST_BUS_OFF_FLAG_FLOAT: assert property (fault_state == FS_BUS_OFF [*2] |-> !can_tx_oe && !rx_enable && !tx_allowed)
      else $error("bus-off node still on the bus");
   AST_BIT_ERR: assert property (tx_chk && ctx.field == F_DATA && $past(can_rx, 2) != ctx.tx_level |=> err_evt.bit_err)
      else $error("bit error missed");
   AST_ARB_LOSS: assert property (tx_chk && ctx.field == F_ARB && ctx.tx_level && !$past(can_rx, 2)
                                  |=> arb_lost && !err_evt.bit_err)
      else $error("arbitration loss mis-reported");
   AST_ACK_SEEN: assert property (tx_chk && ctx.field == F_ACK_SLOT && !$past(can_rx, 2) |=> err_evt == '0)
      else $error("acknowledge taken as error");
   AST_FORM: assert property (ce && ctx.tick && rx_enable && tx_allowed && !$past(can_rx, 2)
                              && ctx.field inside {F_CRC_DELIM, F_ACK_DELIM, F_EOF, F_IFS} |=> err_evt.form_err)
      else $error("form error missed");
   AST_ACTIVE_FLAG: assert property (err_evt != '0 && fault_state == FS_ACTIVE |-> ##[0:2] !can_tx)
      else $error("active flag not dominant");
   AST_PASSIVE_FLAG: assert property (err_evt != '0 && fault_state == FS_PASSIVE && ctx.tx_level |=> can_tx [*6])
      else $error("passive flag drove dominant");
   AST_EVT_TICK: assert property (err_evt != '0 |-> $past(ctx.tick) ##1 err_evt == '0)
      else $error("event not a pulse after a tick");

   COV_BIT: cover property (err_evt.bit_err);
   COV_ARB: cover property (arb_lost);
   COV_BUS_OFF_FLAG: cover property (fault_state == FS_BUS_OFF);
endmodule : can_edc_asserts

// ==== can_far_node.sv ====
// the other nodes on the shared bus: wired-and line with a recessive pull-up
`timescale 1ns/1ps
module can_far_node (
   input  wire logic dut_tx,
   input  wire logic dut_oe,
   input  wire logic far_dom,
   output logic      bus
);
   // a floated driver leaves the line to the pull-up, so it reads recessive
   assign bus = (dut_oe ? dut_tx : 1'b1) & !far_dom;
endmodule : can_far_node

// ==== tb.sv ====
// self-checking bench for the can error detection and confinement block
`timescale 1ns/1ps
module tb;
   import can_edc_pkg::*;
   localparam int ADDR_W = 12;
   logic              pclk = 1'b0;
   logic              presetn = 1'b0;
   logic              ce = 1'b1;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0]       pwdata = '0;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   frame_ctx_t        ctx = '{1'b0, 1'b0, 1'b1, F_IDLE, 1'b0};
   logic              can_rx;
   logic              can_tx;
   logic              can_tx_oe;
   logic              rx_enable;
   logic              tx_allowed;
   logic              arb_lost;
   err_evt_t          err_evt;
   fault_t            fault_state;
   logic              far_dom = 1'b0;
   err_evt_t          seen;
   err_evt_t          acc;
   logic              seen_arb;
   logic [31:0]       rd;
   logic              err;
   int                dom;
   int                ta_low;
   int                n_mismatch = 0;
   int                cmp_count = 0;

   always #4 pclk = ~pclk;

   can_error_detect_confine #(.ADDR_W(ADDR_W)) dut (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ctx(ctx),
      .can_rx(can_rx), .can_tx(can_tx), .can_tx_oe(can_tx_oe), .rx_enable(rx_enable),
      .tx_allowed(tx_allowed), .arb_lost(arb_lost), .err_evt(err_evt), .fault_state(fault_state));
   can_far_node far (.dut_tx(can_tx), .dut_oe(can_tx_oe), .far_dom(far_dom), .bus(can_rx));

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : close_out

   task automatic chk(logic [31:0] got, logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(logic wr, logic [ADDR_W-1:0] a, logic [31:0] wd);
      int i;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 8);
      if (pready !== 1'b1) begin
         n_mismatch++;
         close_out();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle cycle so a following call never reassigns psel in this time step
      @(posedge pclk);
   endtask : apb

   // one bit time of five cycles; the tick comes late so the two rx flops hold this bit
   task automatic bit1(field_t f, logic tr, logic tl, logic fd);
      ctx.field <= f;
      ctx.transmitting <= tr;
      ctx.tx_level <= tl;
      far_dom <= fd;
      repeat (3) @(posedge pclk);
      if (can_tx === 1'b0) dom++;
      if (tx_allowed !== 1'b1) ta_low++;
      ctx.tick <= 1'b1;
      @(posedge pclk);
      ctx.tick <= 1'b0;
      @(posedge pclk);
      seen = err_evt;
      seen_arb = arb_lost;
      acc = acc | seen;
   endtask : bit1

   task automatic run(int n);
      dom = 0;
      ta_low = 0;
      repeat (n) bit1(F_IDLE, 1'b0, 1'b1, 1'b0);
   endtask : run

   task automatic done_pulse();
      ctx.transmitting <= 1'b1;
      ctx.frame_done <= 1'b1;
      @(posedge pclk);
      ctx.frame_done <= 1'b0;
      ctx.transmitting <= 1'b0;
      @(posedge pclk);
   endtask : done_pulse

   task automatic berr();
      bit1(F_DATA, 1'b1, 1'b1, 1'b1);
      chk(seen.bit_err, 1'b1);
      run(30);
   endtask : berr

   task automatic t_regs();
      apb(1'b1, 12'h002, 32'h0);
      chk(err, 1'b1);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h1);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0);
      $display("registers done");
   endtask : t_regs

   task automatic t_arb();
      acc = '0;
      bit1(F_ARB, 1'b1, 1'b1, 1'b1);
      chk(seen_arb, 1'b1);
      bit1(F_ACK_SLOT, 1'b1, 1'b1, 1'b1);
      chk(acc, 32'h0);
      $display("arbitration and ack done");
   endtask : t_arb

   task automatic t_ce();
      ce <= 1'b0;
      bit1(F_DATA, 1'b1, 1'b1, 1'b1);
      chk(seen, 32'h0);
      ce <= 1'b1;
      run(2);
      chk(fault_state, FS_ACTIVE);
      $display("clock enable done");
   endtask : t_ce

   task automatic t_form();
      field_t ff [4];
      ff = '{F_CRC_DELIM, F_ACK_DELIM, F_EOF, F_IFS};
      foreach (ff[i]) begin
         bit1(ff[i], 1'b0, 1'b1, 1'b1);
         chk(seen.form_err, 1'b1);
         run(20);
         chk(dom, 6);
         chk(ta_low, 14);
      end
      $display("form errors done");
   endtask : t_form

   task automatic t_stuff();
      acc = '0;
      bit1(F_SOF, 1'b0, 1'b1, 1'b1);
      repeat (4) bit1(F_ARB, 1'b0, 1'b1, 1'b1);
      chk(acc, 32'h0);
      bit1(F_ARB, 1'b0, 1'b1, 1'b1);
      chk(seen.stuff_err, 1'b1);
      run(20);
      $display("stuffing done");
   endtask : t_stuff

   task automatic t_crc(logic flip);
      logic [25:0] hdr;
      logic [14:0] c;
      logic [40:0] s;
      logic        last;
      int          run_n;
      field_t      f;
      hdr = {1'b0, 11'h123, 6'h08, 8'ha5};
      c = '0;
      for (int i = 25; i >= 0; i--)
         c = {c[13:0], 1'b0} ^ ((hdr[i] ^ c[14]) ? 15'h4599 : 15'h0);
      s = {hdr, c[14:1], c[0] ^ flip};
      run_n = 0;
      last = 1'b1;
      acc = '0;
      for (int i = 40; i >= 0; i--) begin
         f = i == 40 ? F_SOF : i >= 29 ? F_ARB : i >= 23 ? F_CTRL : i >= 15 ? F_DATA : F_CRC;
         if (run_n == 5) begin
            bit1(f, 1'b0, 1'b1, last);
            last = !last;
            run_n = 1;
         end
         run_n = (s[i] == last) ? run_n + 1 : 1;
         last = s[i];
         bit1(f, 1'b0, 1'b1, !s[i]);
      end
      if (run_n == 5) bit1(F_CRC, 1'b0, 1'b1, last);
      bit1(F_CRC_DELIM, 1'b0, 1'b1, 1'b0);
      bit1(F_ACK_SLOT, 1'b0, 1'b1, 1'b0);
      bit1(F_ACK_DELIM, 1'b0, 1'b1, 1'b0);
      chk(acc, {2'b00, flip, 2'b00});
      run(20);
      $display("crc frame done");
   endtask : t_crc

   task automatic t_conf();
      repeat (15) berr();
      chk(fault_state, FS_ACTIVE);
      berr();
      chk(fault_state, FS_PASSIVE);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h41);
      done_pulse();
      chk(fault_state, FS_ACTIVE);
      berr();
      berr();
      chk(dom, 0);
      done_pulse();
      run(12);
      chk(ta_low, 10);
      repeat (4) begin
         bit1(F_ACK_SLOT, 1'b1, 1'b1, 1'b0);
         chk(seen.ack_err, 1'b1);
         run(30);
      end
      repeat (14) berr();
      chk(fault_state, FS_PASSIVE);
      berr();
      chk({can_tx_oe, rx_enable, fault_state}, {2'b00, FS_BUS_OFF});
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'hc2);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h1);
      apb(1'b1, 12'h000, 32'h0);
      run(1407);
      chk(fault_state, FS_BUS_OFF);
      run(1);
      chk(fault_state, FS_ACTIVE);
      $display("confinement done");
   endtask : t_conf

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_arb();
      t_ce();
      t_form();
      t_stuff();
      t_crc(1'b0);
      t_crc(1'b1);
      t_conf();
      close_out();
   end
endmodule : tb

bind can_error_detect_confine can_edc_asserts #(.ADDR_W(ADDR_W)) u_chk (
   .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .ctx(ctx), .can_rx(can_rx), .can_tx(can_tx), .can_tx_oe(can_tx_oe),
   .rx_enable(rx_enable), .tx_allowed(tx_allowed), .arb_lost(arb_lost), .err_evt(err_evt),
   .fault_state(fault_state));
